//--- core/jlcc_pkg.sv
/*
  Constants, register map and carrier types of the link configuration checker.
  Assumes rates are programmed in units of 100 kbit/s (lane) and 100 kHz (sample clock).
*/
`default_nettype none

package jlcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL     = 12'h000;
  localparam logic [11:0] IDX_LANE_RT  = 12'h001;
  localparam logic [11:0] IDX_SMP_RT   = 12'h002;
  localparam logic [11:0] IDX_FRAME    = 12'h003;
  localparam logic [11:0] IDX_LANES    = 12'h004;
  localparam logic [11:0] IDX_STATUS   = 12'h005;
  localparam logic [11:0] IDX_BAND     = 12'h56E;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_MSB      = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layouts and reset values
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_HD_BIT  = 1;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0003;
  localparam logic [31:0] RATE_MASK    = 32'h0003_FFFF;
  localparam logic [31:0] FRAME_MASK   = 32'h3F3F_1F3F;
  localparam logic [31:0] LANES_MASK   = 32'h001F_1F1F;
  localparam logic [31:0] BAND_MASK    = 32'h0000_00FF;
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [7:0]  BAND_RESET   = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Link limits; rates in 100 kbit/s
  localparam logic [17:0] RATE_MIN     = 18'd16875;
  localparam logic [17:0] RATE_MAX     = 18'd155000;
  localparam logic [17:0] BAND3_LO     = 18'd135000;
  localparam logic [17:0] BAND2_LO     = 18'd67500;
  localparam logic [17:0] BAND1_LO     = 18'd33750;
  localparam logic [7:0]  BAND3_CODE   = 8'h30;
  localparam logic [7:0]  BAND2_CODE   = 8'h00;
  localparam logic [7:0]  BAND1_CODE   = 8'h10;
  localparam logic [7:0]  BAND0_CODE   = 8'h50;
  localparam logic [23:0] CLK_RATIO    = 24'd40;
  localparam logic [22:0] LCM_SCALE    = 23'd20;
  localparam logic [6:0]  LCM_MAX      = 7'd64;
  localparam logic [5:0]  DECIM_MAX    = 6'd48;
  localparam logic [5:0]  K_MAX        = 6'd32;
  localparam logic [5:0]  K_MIN_F1     = 6'd20;
  localparam logic [5:0]  K_MIN_F2     = 6'd12;
  localparam logic [5:0]  K_MIN_F4     = 6'd8;
  localparam logic [5:0]  K_MIN_F8     = 6'd4;
  localparam logic [3:0]  WORD_BITS    = 4'd12;
  localparam logic [3:0]  RES_MIN      = 4'd8;
  localparam logic [3:0]  RES_MAX      = 4'd12;
  localparam int          SMP_W        = 12;
  localparam int          CTL_W        = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types, laid out as their register words
  typedef struct packed {
    logic [1:0] pad3;
    logic [1:0] ctrl_bits;
    logic [3:0] res_bits;
    logic [1:0] pad2;
    logic [5:0] frames_mf;
    logic [2:0] pad1;
    logic [4:0] octets;
    logic [1:0] pad0;
    logic [5:0] decim_ratio;
  } jlcc_frame_s;

  typedef struct packed {
    logic [10:0] pad2;
    logic [4:0]  spf;
    logic [2:0]  pad1;
    logic [4:0]  convs;
    logic [2:0]  pad0;
    logic [4:0]  lanes;
  } jlcc_lanes_s;

  typedef struct packed {
    logic [7:0] pad1;
    logic [7:0] band_expected;
    logic [6:0] pad0;
    logic       decim_err;
    logic       fmt_err;
    logic       frame_err;
    logic       band_err;
    logic       lcm_err;
    logic       ratio_err;
    logic       range_err;
    logic       cfg_invalid;
    logic       busy;
  } jlcc_status_s;

endpackage

`default_nettype wire

//--- core/jlcc_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module jlcc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("jlcc_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // jlcc_fifo

`default_nettype wire

//--- core/jlcc_top.sv
/*
  Link configuration checker with AXI4-Lite registers and a decimating sample path.
  Assumes an AXI4-Lite master with one write and one read outstanding at most.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module jlcc_top #(
  parameter int ADDR_W     = 16,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic      [31:0]                 s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        smp_valid,
  output logic                             smp_ready,
  input  wire logic [jlcc_pkg::SMP_W-1:0]  smp_data,
  input  wire logic [jlcc_pkg::CTL_W-1:0]  smp_ctrl,
  output logic                             word_valid,
  input  wire logic                        word_ready,
  output logic      [jlcc_pkg::SMP_W-1:0]  word_data,
  output logic                             cfg_invalid
);

  if (ADDR_W <= jlcc_pkg::IDX_MSB || FIFO_DEPTH < 2)
  begin : g_bad_param
    $error("jlcc_top: ADDR_W must exceed 13 and FIFO_DEPTH must be at least 2");
  end

  typedef enum logic [1:0] {CK_IDLE, CK_DIV, CK_LCM} jlcc_ck_e;

  logic [11:0]           aw_idx_reg;
  logic                  aw_hold_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  w_hold_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  logic [31:0]           rd_word;
  logic                  rd_hit;
  logic                  wr_do;
  logic                  wr_hit;
  logic                  cfg_write;
  logic [11:0]           ar_idx;
  logic [31:0]           ctrl_reg;
  logic [31:0]           lane_rt_reg;
  logic [31:0]           smp_rt_reg;
  jlcc_pkg::jlcc_frame_s frame_reg;
  jlcc_pkg::jlcc_lanes_s lanes_reg;
  logic [7:0]            band_reg;
  jlcc_pkg::jlcc_status_s status;
  logic [17:0]           lane_rate;
  logic [17:0]           smp_rate;
  logic [7:0]            band_exp;
  logic                  frame_ok;
  logic                  fmt_ok;
  logic                  run_ok;
  jlcc_ck_e              ck_state_reg;
  logic [22:0]           num_reg;
  logic [6:0]            quot_reg;
  logic [6:0]            mul_reg;
  logic [6:0]            rq_reg;
  logic [5:0]            rd_reg;
  logic                  lcm_err_reg;
  logic [5:0]            dec_cnt_reg;
  logic                  push_valid;
  logic                  fifo_in_ready;
  logic [11:0]           smp_word;
  logic [3:0]            ctl_mask;
  logic [3:0]            ctl_shift;

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_reg(input logic [11:0] idx);
    return idx == jlcc_pkg::IDX_CTRL || idx == jlcc_pkg::IDX_LANE_RT ||
           idx == jlcc_pkg::IDX_SMP_RT || idx == jlcc_pkg::IDX_FRAME ||
           idx == jlcc_pkg::IDX_LANES || idx == jlcc_pkg::IDX_STATUS ||
           idx == jlcc_pkg::IDX_BAND;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_do         = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_hit        = is_reg(aw_idx_reg) && aw_idx_reg != jlcc_pkg::IDX_STATUS;
  assign cfg_write     = bvalid_reg && (aw_idx_reg == jlcc_pkg::IDX_LANE_RT ||
                         aw_idx_reg == jlcc_pkg::IDX_SMP_RT || aw_idx_reg == jlcc_pkg::IDX_FRAME);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_idx_reg  <= '0;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[jlcc_pkg::IDX_MSB:jlcc_pkg::IDX_LSB];
      end
      else if (wr_do)
      begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_do)
      begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= jlcc_pkg::RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? jlcc_pkg::RESP_OKAY : jlcc_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= '0;
      lane_rt_reg <= '0;
      smp_rt_reg  <= '0;
      frame_reg   <= '0;
      lanes_reg   <= '0;
      band_reg    <= jlcc_pkg::BAND_RESET;
    end
    else if (wr_do)
    begin
      case (aw_idx_reg)
        jlcc_pkg::IDX_CTRL:
          ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & jlcc_pkg::CTRL_MASK;
        jlcc_pkg::IDX_LANE_RT:
          lane_rt_reg <= merge(lane_rt_reg, w_data_reg, w_strb_reg) & jlcc_pkg::RATE_MASK;
        jlcc_pkg::IDX_SMP_RT:
          smp_rt_reg <= merge(smp_rt_reg, w_data_reg, w_strb_reg) & jlcc_pkg::RATE_MASK;
        jlcc_pkg::IDX_FRAME:
          frame_reg <= merge(frame_reg, w_data_reg, w_strb_reg) & jlcc_pkg::FRAME_MASK;
        jlcc_pkg::IDX_LANES:
          lanes_reg <= merge(lanes_reg, w_data_reg, w_strb_reg) & jlcc_pkg::LANES_MASK;
        jlcc_pkg::IDX_BAND:
          band_reg <= 8'(merge({24'h00_0000, band_reg}, w_data_reg, w_strb_reg));
        default:
          ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign ar_idx        = s_axi_araddr[jlcc_pkg::IDX_MSB:jlcc_pkg::IDX_LSB];
  assign rd_hit        = is_reg(ar_idx);
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb
  begin
    case (ar_idx)
      jlcc_pkg::IDX_CTRL:    rd_word = ctrl_reg;
      jlcc_pkg::IDX_LANE_RT: rd_word = lane_rt_reg;
      jlcc_pkg::IDX_SMP_RT:  rd_word = smp_rt_reg;
      jlcc_pkg::IDX_FRAME:   rd_word = frame_reg;
      jlcc_pkg::IDX_LANES:   rd_word = lanes_reg;
      jlcc_pkg::IDX_STATUS:  rd_word = status;
      jlcc_pkg::IDX_BAND:    rd_word = {24'h00_0000, band_reg};
      default:               rd_word = jlcc_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= jlcc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? jlcc_pkg::RESP_OKAY : jlcc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Static checks
  assign lane_rate = lane_rt_reg[17:0];
  assign smp_rate  = smp_rt_reg[17:0];

  always_comb
  begin
    if (lane_rate > jlcc_pkg::BAND3_LO)
      band_exp = jlcc_pkg::BAND3_CODE;
    else if (lane_rate >= jlcc_pkg::BAND2_LO)
      band_exp = jlcc_pkg::BAND2_CODE;
    else if (lane_rate >= jlcc_pkg::BAND1_LO)
      band_exp = jlcc_pkg::BAND1_CODE;
    else
      band_exp = jlcc_pkg::BAND0_CODE;
  end

  always_comb
  begin
    case (frame_reg.octets)
      5'd1:    frame_ok = frame_reg.frames_mf >= jlcc_pkg::K_MIN_F1;
      5'd2:    frame_ok = frame_reg.frames_mf >= jlcc_pkg::K_MIN_F2;
      5'd4:    frame_ok = frame_reg.frames_mf >= jlcc_pkg::K_MIN_F4;
      5'd8,
      5'd16:   frame_ok = frame_reg.frames_mf >= jlcc_pkg::K_MIN_F8;
      default: frame_ok = frame_reg.octets != 5'd0 && frame_reg.frames_mf != 6'd0;
    endcase
    if (frame_reg.octets == 5'd1 || frame_reg.octets == 5'd2 || frame_reg.octets == 5'd4 ||
        frame_reg.octets == 5'd8 || frame_reg.octets == 5'd16)
      frame_ok = frame_ok && frame_reg.frames_mf[1:0] == 2'b00;
    frame_ok = frame_ok && frame_reg.frames_mf <= jlcc_pkg::K_MAX &&
               ((frame_reg.frames_mf[1:0] * frame_reg.octets[1:0]) & 2'b11) == 2'b00;
  end

  assign fmt_ok = frame_reg.res_bits >= jlcc_pkg::RES_MIN &&
                  frame_reg.res_bits <= jlcc_pkg::RES_MAX &&
                  ({2'b00, frame_reg.ctrl_bits} + frame_reg.res_bits) <= jlcc_pkg::WORD_BITS;

  always_comb
  begin
    status               = '0;
    status.busy          = ck_state_reg != CK_IDLE || cfg_write;
    status.range_err     = lane_rate < jlcc_pkg::RATE_MIN || lane_rate > jlcc_pkg::RATE_MAX;
    status.ratio_err     = {6'h00, lane_rate} > 24'(smp_rate) * jlcc_pkg::CLK_RATIO;
    status.lcm_err       = lcm_err_reg;
    status.band_err      = band_reg != band_exp;
    status.frame_err     = !frame_ok;
    status.fmt_err       = !fmt_ok;
    status.decim_err     = frame_reg.decim_ratio == 6'd0 ||
                           frame_reg.decim_ratio > jlcc_pkg::DECIM_MAX;
    status.band_expected = band_exp;
    status.cfg_invalid   = status.busy || status.range_err || status.ratio_err || status.lcm_err ||
                           status.band_err || status.frame_err || status.fmt_err ||
                           status.decim_err;
  end

  assign cfg_invalid = status.cfg_invalid;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequential lcm check: q = 20*fs/rate, then find a common multiple of q and D up to 64
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_state_reg <= CK_IDLE;
      num_reg      <= '0;
      quot_reg     <= '0;
      mul_reg      <= '0;
      rq_reg       <= '0;
      rd_reg       <= '0;
      lcm_err_reg  <= 1'b1;
    end
    else if (cfg_write)
    begin
      ck_state_reg <= CK_DIV;
      num_reg      <= 23'(smp_rate) * jlcc_pkg::LCM_SCALE;
      quot_reg     <= '0;
    end
    else
    begin
      case (ck_state_reg)
        CK_DIV:
          if (lane_rate == 18'd0 || quot_reg > jlcc_pkg::LCM_MAX)
          begin
            lcm_err_reg  <= 1'b1;
            ck_state_reg <= CK_IDLE;
          end
          else if (num_reg >= {5'h00, lane_rate})
          begin
            num_reg  <= num_reg - {5'h00, lane_rate};
            quot_reg <= quot_reg + 7'd1;
          end
          else if (num_reg != 23'd0 || quot_reg == 7'd0 || frame_reg.decim_ratio == 6'd0)
          begin
            lcm_err_reg  <= 1'b1;
            ck_state_reg <= CK_IDLE;
          end
          else
          begin
            mul_reg      <= 7'd1;
            rq_reg       <= (quot_reg == 7'd1) ? 7'd0 : 7'd1;
            rd_reg       <= (frame_reg.decim_ratio == 6'd1) ? 6'd0 : 6'd1;
            ck_state_reg <= CK_LCM;
          end
        CK_LCM:
          if (rq_reg == 7'd0 && rd_reg == 6'd0)
          begin
            lcm_err_reg  <= 1'b0;
            ck_state_reg <= CK_IDLE;
          end
          else if (mul_reg >= jlcc_pkg::LCM_MAX)
          begin
            lcm_err_reg  <= 1'b1;
            ck_state_reg <= CK_IDLE;
          end
          else
          begin
            mul_reg <= mul_reg + 7'd1;
            rq_reg  <= (rq_reg + 7'd1 == quot_reg) ? 7'd0 : rq_reg + 7'd1;
            rd_reg  <= (rd_reg + 6'd1 == frame_reg.decim_ratio) ? 6'd0 : rd_reg + 6'd1;
          end
        default:
          ck_state_reg <= CK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample path: keep one of every D input samples and format it into a 12-bit word
  assign run_ok     = ctrl_reg[jlcc_pkg::CTRL_EN_BIT] && !status.cfg_invalid;
  assign smp_ready  = !run_ok || fifo_in_ready;
  assign push_valid = run_ok && smp_valid && dec_cnt_reg == frame_reg.decim_ratio - 6'd1;
  assign ctl_mask   = (4'h1 << frame_reg.ctrl_bits) - 4'h1;
  assign ctl_shift  = jlcc_pkg::WORD_BITS - frame_reg.res_bits - {2'b00, frame_reg.ctrl_bits};
  assign smp_word   = (smp_data & (12'hFFF << (jlcc_pkg::WORD_BITS - frame_reg.res_bits))) |
                      ({9'h000, smp_ctrl & ctl_mask[2:0]} << ctl_shift);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_ok)
    begin
      dec_cnt_reg <= '0;
    end
    else if (smp_valid && smp_ready)
    begin
      dec_cnt_reg <= push_valid ? 6'd0 : dec_cnt_reg + 6'd1;
    end
  end

  jlcc_fifo #(
    .WIDTH (jlcc_pkg::SMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (smp_word),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

endmodule // jlcc_top

`default_nettype wire

//--- bench/jlcc_asserts.sv
/* Port checker of jlcc_top.
   Assumes a bind to every jlcc_top instance. */
`timescale 1ns/10ps
`default_nettype none
module jlcc_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        smp_ready,
  input wire logic        word_valid,
  input wire logic        word_ready,
  input wire logic [11:0] word_data,
  input wire logic        cfg_invalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r lost");
  AST_AW_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
  AST_AR_BLOCK:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  AST_WORD_HOLD:
    assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
      else $error("word changed");
  AST_FULL_STOP:
    assert property (!smp_ready |-> !cfg_invalid && word_valid) else $error("bad stop");
  AST_RESET_BAD:
    assert property ($rose(aresetn) |-> cfg_invalid) else $error("valid at reset");
  AST_IDLE_DROP:
    assert property (cfg_invalid && !word_valid |=> !word_valid) else $error("idle push");
  cover property (!smp_ready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (word_valid && word_ready);
endmodule // jlcc_asserts
bind jlcc_top jlcc_asserts jlcc_asserts_i (.*);
`default_nettype wire

//--- bench/jlcc_rx_model.sv
/* Receiver stand-in taking output words.
   Assumes stall high back-pressures it. */
`timescale 1ns/10ps
`default_nettype none
module jlcc_rx_model (
  input  wire logic        aclk,
  input  wire logic        stall,
  input  wire logic        word_valid,
  input  wire logic [11:0] word_data,
  output logic             word_ready,
  output logic      [11:0] last_word,
  output int               n_words
);
  assign word_ready = !stall;
  initial n_words = 0;
  always @(posedge aclk)
    if (word_valid && word_ready)
    begin
      last_word <= word_data;
      n_words <= n_words + 1;
    end
endmodule // jlcc_rx_model
`default_nettype wire

//--- bench/tb_jlcc_link_config_check.sv
/* Bench of jlcc_top.
   Assumes the package, core, model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_jesd_link_config_check;
  logic        aclk, aresetn, stall, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, a;
  logic        s_axi_rready, smp_valid, smp_ready, word_valid, word_ready, cfg_invalid;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [11:0] smp_data, word_data, last_word;
  logic [2:0]  smp_ctrl;
  int          num_errors, n_checks, n_words, i, n;
  logic [17:0] rt [7] = '{18'h25D78, 18'h20F58, 18'h107AC, 18'h107AB, 18'h83D6, 18'h83D5, 18'h41EB};
  logic [7:0]  bc [7] = '{8'h30, 8'h00, 8'h00, 8'h10, 8'h10, 8'h50, 8'h50};
  logic [31:0] fw [8] = '{32'h0C100101, 32'h0C140101, 32'h0C080201, 32'h0C0C0201,
                          32'h0C040401, 32'h0C080401, 32'h0C040801, 32'h0C241001};
  logic [7:0]  fe = 8'h95;
  jlcc_top jlcc_top_i (.*);
  jlcc_rx_model jlcc_rx_model_i (.*);
  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [15:0] ad, input logic [31:0] d);
    int k;
    logic ta, tw, tb;
    @(posedge aclk);
    if (rd)
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    else
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'h7};
    for (k = 0; k < 64; k++)
    begin
      @(negedge aclk);
      if (!(s_axi_awvalid | s_axi_wvalid | s_axi_bready | s_axi_arvalid | s_axi_rready))
        break;
      ta = s_axi_awvalid & s_axi_awready | s_axi_arvalid & s_axi_arready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
      q = s_axi_rdata;
      r = rd ? s_axi_rresp : s_axi_bresp;
      @(posedge aclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) {s_axi_bready, s_axi_rready} <= 2'h0;
    end
    if (k == 64)
    begin
      num_errors++;
      tally_and_finish;
    end
  endtask
  task automatic t_regs;
    bus(1'h1, 16'h15B8, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, 16'h15B8, 32'hA5A5A555);
    bus(1'h1, 16'h15B8, 32'h0);
    chk(q, 32'h55);
    bus(1'h0, 16'h0000, 32'hFFFFFFFF);
    bus(1'h1, 16'h0000, 32'h0);
    chk(q, 32'h3);
    bus(1'h1, 16'h0100, 32'h0);
    chk({r, q[29:0]}, 32'h80000000);
    bus(1'h0, 16'h0014, 32'h0);
    chk({30'h0, r}, 32'h2);
    $display("registers done");
  endtask
  task automatic t_band;
    for (i = 0; i < 7; i++)
    begin
      bus(1'h0, 16'h0004, {14'h0, rt[i]});
      bus(1'h1, 16'h0014, 32'h0);
      chk({24'h0, q[23:16]}, {24'h0, bc[i]});
    end
    bus(1'h0, 16'h0004, 32'h41EA);
    bus(1'h1, 16'h0014, 32'h0);
    chk({31'h0, q[2]}, 32'h1);
    $display("band done");
  endtask
  task automatic t_frame;
    for (i = 0; i < 8; i++)
    begin
      bus(1'h0, 16'h000C, fw[i]);
      bus(1'h1, 16'h0014, 32'h0);
      chk({31'h0, q[6]}, {31'h0, fe[i]});
    end
    $display("frame done");
  endtask
  task automatic t_stream;
    bus(1'h0, 16'h0004, 32'h107AC);
    bus(1'h0, 16'h0008, 32'h83D6);
    bus(1'h0, 16'h000C, 32'h2A140202);
    bus(1'h0, 16'h15B8, 32'h0);
    bus(1'h0, 16'h0000, 32'h1);
    for (i = 0; i < 60; i++)
    begin
      bus(1'h1, 16'h0014, 32'h0);
      if (q[0] === 1'h0)
        break;
    end
    chk({23'h0, q[8:0]}, 32'h0);
    chk({31'h0, cfg_invalid}, 32'h0);
    @(posedge aclk);
    {smp_valid, smp_data, smp_ctrl, n} <= {1'h1, 12'h100, 3'h5, 32'h0};
    repeat (20)
    begin
      @(negedge aclk);
      a = smp_ready;
      @(posedge aclk);
      if (a) {n, smp_data} <= {n + 1, smp_data + 12'h001};
    end
    smp_valid <= 1'h0;
    stall <= 1'h0;
    chk(n, 32'h10);
    for (i = 0; i < 40 && n_words < 8; i++)
      @(posedge aclk);
    chk(n_words, 32'h8);
    chk({20'h0, last_word}, 32'h10D);
    $display("stream done");
  endtask
  initial
  begin
    {aresetn, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h10;
    {s_axi_rready, smp_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, smp_data, smp_ctrl} = '0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_band;
    t_frame;
    t_stream;
    tally_and_finish;
  end
endmodule // tb_jesd_link_config_check
`default_nettype wire
